// [verilog/csef_top.sv]
// Behaviour
// - lost mode reports lowest lost mailbox
// - after clear, next mailbox; none sets empty
// - fifo mode reports mailbox 28 on fifo loss
// - channel mode encodes table bits lowest first
// - each result read advances to next channel
// - frame error bumps tx or rx counter
// - counter at 96 sets warning flag
// - counter at 128 enters passive, flags it
// - tx counter at 256 enters bus-off
// - per-source enables and source register
// - state register shows passive and bus-off
// - leave bus-off after 128 recessive runs
// - mode 00 recovers to active, flags recovery
// - forced recovery bit returns, self-clears
// - mode 01 halts at bus-off start, no flag
// - mode 10 halts after recovery, flags it
// - mode 11 halts on halt request, else 00
// - 11-bit standard, 29-bit extended identifiers
// - masked compare, accept when all match
// - mask-invalid bit disables mask per mailbox
// - compare rtr always, ide only mixed; here rtr is compared only with mask bit 29 set or mask invalid
// - modes 00/01 search rx/tx complete flags
// - fifo lost set on arrival when full
//
// The placing of the registers and the APB slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "csef_regs.svh"
module csef_top #(
	parameter int NMBOX = 32,
	parameter int NCHAN = 8,
	parameter int FIFO_DEPTH = 4
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic frameErr,
	input wire logic errWhileTx,
	input wire logic recessRun,
	input wire logic rxArrive,
	input wire logic [4:0] rxMbox,
	input wire logic rxDone,
	input wire logic [4:0] txMbox,
	input wire logic txDone,
	input wire logic fifoLevelPush,
	input wire logic fifoLevelPop,
	input wire logic [28:0] rxId,
	input wire logic rxIde,
	input wire logic rxRtr,
	input wire logic [4:0] filtMbox,
	output logic acceptOut,
	output logic busoffOut,
	output logic haltOut
);
	logic [31:0] ctrl_r;
	logic [1:0] smode_r;
	logic [NCHAN-1:0] chTab_r;
	logic [4:0] ien_r;
	logic [4:0] isrc_r;
	logic [NMBOX-1:0] lost_r;
	logic [NMBOX-1:0] rxc_r;
	logic [NMBOX-1:0] txc_r;
	logic [NMBOX-1:0] minv_r;
	logic fifoLost_r;
	logic [2:0] fifoCnt_r;
	logic [8:0] tec_r;
	logic [7:0] rec_r;
	logic [7:0] runCnt_r;
	logic [30:0] mbId_r;
	logic [30:0] mask_r;
	logic [7:0] ictl_r;
	csef_pkg::csef_fc_e fc_r;
	logic [5:0] sres_r;
	logic sempty_r;
	logic [31:0] prdata_r;
	logic pready_r;
	logic pslverr_r;
	logic accept_r;
	wire logic fifoMode = ctrl_r[`CSEF_CTRL_FIFO];
	wire logic [1:0] busoffRecoverySel = ctrl_r[`CSEF_CTRL_RECSEL +: 2];
	wire logic [1:0] operatingModeSel = ctrl_r[`CSEF_CTRL_OPMODE +: 2];
	wire logic forcedRecoveryBit = ctrl_r[`CSEF_CTRL_FRCREC];
	wire logic [1:0] idfm = ctrl_r[`CSEF_CTRL_IDFM +: 2];
	wire logic inReset = (operatingModeSel == 2'h1);
	wire logic setup = psel && !penable;
	wire logic wrEn = setup && pwrite;
	wire logic rdEn = setup && !pwrite;
	wire logic resRead = rdEn && (paddr == `CSEF_OFF_SRES);
	wire logic boff = (fc_r == csef_pkg::FC_BUSOFF);
	function automatic logic [5:0] lowest(input logic [NMBOX-1:0] v);
		logic [5:0] r;
		r = 6'h20;
		for (int i = NMBOX - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = 6'(i);
			end
		end
		return r;
	endfunction
	function automatic logic wrAt(input logic [11:0] off);
		return wrEn && (paddr == off);
	endfunction
	logic [NMBOX-1:0] lostView;
	logic [NMBOX-1:0] rxView;
	logic [NMBOX-1:0] selView;
	logic [5:0] hit;
	always_comb begin
		lostView = lost_r;
		rxView = rxc_r;
		if (fifoMode) begin
			lostView[`CSEF_FIFO_MBOX] = fifoLost_r;
			rxView[`CSEF_FIFO_MBOX] = (fifoCnt_r != 3'h0);
		end else begin
			lostView[`CSEF_FIFO_MBOX] = lost_r[`CSEF_FIFO_MBOX] | fifoLost_r;
		end
		unique case (csef_pkg::csef_smode_e'(smode_r))
			csef_pkg::SM_RX: selView = rxView;
			csef_pkg::SM_TX: selView = txc_r;
			csef_pkg::SM_LOST: selView = lostView;
			csef_pkg::SM_CHAN: selView = NMBOX'(chTab_r);
		endcase
		hit = lowest(selView);
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sres_r <= 6'h00;
			sempty_r <= 1'b1;
		end else if (clkEn) begin
			sres_r <= hit;
			sempty_r <= (selView == '0);
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			chTab_r <= '0;
		end else if (clkEn) begin
			if (wrAt(`CSEF_OFF_CHTAB)) begin
				chTab_r <= pwdata[NCHAN-1:0];
			end else if (resRead && smode_r == 2'h3 && !sempty_r) begin
				chTab_r[sres_r[2:0]] <= 1'b0;
			end
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctrl_r <= 32'h00000010;
			smode_r <= 2'h0;
			ien_r <= 5'h00;
			minv_r <= '0;
			mbId_r <= '0;
			mask_r <= '0;
			ictl_r <= 8'h00;
		end else if (clkEn) begin
			if (wrAt(`CSEF_OFF_CTRL)) begin
				ctrl_r <= pwdata;
			end else if (forcedRecoveryBit || !boff) begin
				ctrl_r[`CSEF_CTRL_FRCREC] <= 1'b0;
			end
			if (wrAt(`CSEF_OFF_SMODE)) begin
				smode_r <= pwdata[1:0];
			end
			if (wrAt(`CSEF_OFF_IEN) && inReset) begin
				ien_r <= pwdata[4:0];
			end
			if (wrAt(`CSEF_OFF_MINV)) begin
				minv_r <= pwdata[NMBOX-1:0];
			end
			if (wrAt(`CSEF_OFF_MBID)) begin
				mbId_r <= pwdata[30:0];
			end
			if (wrAt(`CSEF_OFF_MASK)) begin
				mask_r <= pwdata[30:0];
			end
			if (wrAt(`CSEF_OFF_ICTL)) begin
				ictl_r <= pwdata[7:0];
			end
		end
	end
	generate
		for (genvar m = 0; m < NMBOX; m++) begin : gMbox
			always_ff @(posedge clock) begin
				if (sys_rst) begin
					lost_r[m] <= 1'b0;
					rxc_r[m] <= 1'b0;
					txc_r[m] <= 1'b0;
				end else if (clkEn) begin
					if (rxArrive && rxMbox == 5'(m) &&
						!(fifoMode && m >= `CSEF_FIFO_MBOX)) begin
						lost_r[m] <= lost_r[m] | rxc_r[m];
						rxc_r[m] <= 1'b1;
					end else begin
						if (wrAt(`CSEF_OFF_LOST) && pwdata[m]) begin
							lost_r[m] <= 1'b0;
						end
						if (wrAt(`CSEF_OFF_RXC) && pwdata[m]) begin
							rxc_r[m] <= 1'b0;
						end
					end
					if (txDone && txMbox == 5'(m)) begin
						txc_r[m] <= 1'b1;
					end else if (wrAt(`CSEF_OFF_TXC) && pwdata[m]) begin
						txc_r[m] <= 1'b0;
					end
				end
			end
		end
	endgenerate
	wire logic fifoFull = (fifoCnt_r == 3'(FIFO_DEPTH));
	wire logic fifoIn = fifoMode && rxArrive && rxMbox >= `CSEF_FIFO_MBOX;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			fifoCnt_r <= 3'h0;
			fifoLost_r <= 1'b0;
		end else if (clkEn) begin
			if (fifoIn && fifoFull) begin
				fifoLost_r <= 1'b1;
			end else if (wrAt(`CSEF_OFF_FIFO) && pwdata[0]) begin
				fifoLost_r <= 1'b0;
			end
			if ((fifoIn || fifoLevelPush) && !fifoFull && !fifoLevelPop) begin
				fifoCnt_r <= fifoCnt_r + 3'h1;
			end else if (fifoLevelPop && !(fifoIn || fifoLevelPush) &&
				fifoCnt_r != 3'h0) begin
				fifoCnt_r <= fifoCnt_r - 3'h1;
			end
		end
	end
	logic boffEnter;
	logic recovered;
	logic [4:0] evt;
	always_comb begin
		boffEnter = frameErr && errWhileTx && !boff &&
			(9'(tec_r + 9'h1) >= `CSEF_BUSOFF_LIMIT);
		recovered = boff && ((recessRun &&
			runCnt_r == 8'(`CSEF_RECESS_TIMES - 8'h1)) ||
			forcedRecoveryBit);
		evt = 5'h00;
		evt[`CSEF_ISRC_BUSERR] = frameErr;
		evt[`CSEF_ISRC_WARN] = frameErr &&
			((errWhileTx && tec_r + 9'h1 == `CSEF_WARN_LIMIT) ||
			(!errWhileTx && {1'b0, rec_r} + 9'h1 == `CSEF_WARN_LIMIT));
		evt[`CSEF_ISRC_PASSIVE] = frameErr &&
			((errWhileTx && tec_r + 9'h1 == `CSEF_PASSIVE_LIMIT) ||
			(!errWhileTx &&
			{1'b0, rec_r} + 9'h1 == `CSEF_PASSIVE_LIMIT));
		evt[`CSEF_ISRC_BOFF] = boffEnter;
		evt[`CSEF_ISRC_BREC] = recovered && !forcedRecoveryBit &&
			(busoffRecoverySel == 2'h0 || busoffRecoverySel == 2'h2 ||
			(busoffRecoverySel == 2'h3 &&
			operatingModeSel != `CSEF_MODE_HALT));
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			tec_r <= 9'h000;
			rec_r <= 8'h00;
		end else if (clkEn) begin
			if (recovered) begin
				tec_r <= 9'h000;
				rec_r <= 8'h00;
			end else if (frameErr && !boff) begin
				if (errWhileTx) begin
					tec_r <= tec_r + 9'h1;
				end else if (rec_r != 8'hFF) begin
					rec_r <= rec_r + 8'h1;
				end
			end
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			runCnt_r <= 8'h00;
		end else if (clkEn) begin
			if (!boff || recovered) begin
				runCnt_r <= 8'h00;
			end else if (recessRun) begin
				runCnt_r <= runCnt_r + 8'h1;
			end
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			isrc_r <= 5'h00;
		end else if (clkEn) begin
			for (int b = 0; b < 5; b++) begin
				if (evt[b] && ien_r[b]) begin
					isrc_r[b] <= 1'b1;
				end else if (wrAt(`CSEF_OFF_ISRC) && pwdata[b]) begin
					isrc_r[b] <= 1'b0;
				end
			end
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			fc_r <= csef_pkg::FC_ACTIVE;
		end else if (clkEn) begin
			unique case (fc_r)
				csef_pkg::FC_ACTIVE, csef_pkg::FC_PASSIVE: begin
					if (boffEnter) begin
						fc_r <= (busoffRecoverySel == 2'h1) ? csef_pkg::FC_HALT :
							csef_pkg::FC_BUSOFF;
					end else if (tec_r >= `CSEF_PASSIVE_LIMIT ||
						{1'b0, rec_r} >= `CSEF_PASSIVE_LIMIT) begin
						fc_r <= csef_pkg::FC_PASSIVE;
					end else begin
						fc_r <= csef_pkg::FC_ACTIVE;
					end
				end
				csef_pkg::FC_BUSOFF: begin
					if (busoffRecoverySel == 2'h3 &&
						operatingModeSel == `CSEF_MODE_HALT) begin
						fc_r <= csef_pkg::FC_HALT;
					end else if (recovered) begin
						fc_r <= (busoffRecoverySel == 2'h2 && !forcedRecoveryBit) ?
							csef_pkg::FC_HALT :
							csef_pkg::FC_ACTIVE;
					end
				end
				csef_pkg::FC_HALT: begin
					if (wrAt(`CSEF_OFF_CTRL) &&
						pwdata[`CSEF_CTRL_OPMODE +: 2] != `CSEF_MODE_HALT) begin
						fc_r <= csef_pkg::FC_ACTIVE;
					end
				end
				default: fc_r <= csef_pkg::FC_ACTIVE;
			endcase
		end
	end
	logic [30:0] rxVec;
	logic [30:0] cmpMask;
	always_comb begin
		rxVec = {rxIde, rxRtr, rxId};
		cmpMask = minv_r[filtMbox] ? '1 : mask_r;
		cmpMask[30] = cmpMask[30] && (idfm == `CSEF_IDFM_MIXED);
		if (!rxIde) begin
			cmpMask[17:0] = 18'h00000;
		end
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			accept_r <= 1'b0;
		end else if (clkEn) begin
			accept_r <= ((rxVec ^ mbId_r) & cmpMask) == '0;
		end
	end
	logic [31:0] rdMux;
	logic rdOk;
	always_comb begin
		rdOk = 1'b1;
		rdMux = 32'h00000000;
		unique case (paddr)
			`CSEF_OFF_CTRL: rdMux = ctrl_r;
			`CSEF_OFF_STATE: rdMux = {28'h0, fc_r == csef_pkg::FC_HALT,
				boff, fc_r == csef_pkg::FC_PASSIVE, inReset};
			`CSEF_OFF_SMODE: rdMux = {30'h0, smode_r};
			`CSEF_OFF_SRES: rdMux = {24'h0, sempty_r, 2'h0, sres_r[4:0]};
			`CSEF_OFF_CHTAB: rdMux = 32'(chTab_r);
			`CSEF_OFF_IEN: rdMux = {27'h0, ien_r};
			`CSEF_OFF_ISRC: rdMux = {27'h0, isrc_r};
			`CSEF_OFF_LOST: rdMux = 32'(lost_r);
			`CSEF_OFF_RXC: rdMux = 32'(rxc_r);
			`CSEF_OFF_TXC: rdMux = 32'(txc_r);
			`CSEF_OFF_FIFO: rdMux = {27'h0, fifoCnt_r, fifoCnt_r == 3'h0,
				fifoLost_r};
			`CSEF_OFF_MINV: rdMux = 32'(minv_r);
			`CSEF_OFF_ERRCNT: rdMux = {7'h0, tec_r, 8'h0, rec_r};
			`CSEF_OFF_MBID: rdMux = {1'b0, mbId_r};
			`CSEF_OFF_MASK: rdMux = {1'b0, mask_r};
			`CSEF_OFF_ICTL: rdMux = {24'h0, ictl_r};
			default: rdOk = 1'b0;
		endcase
	end
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			prdata_r <= 32'h00000000;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else if (clkEn) begin
			pready_r <= setup;
			pslverr_r <= setup && !rdOk;
			if (rdEn) begin
				prdata_r <= rdMux;
			end
		end
	end
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign acceptOut = accept_r;
	// one-hot state bits, taken straight from the state flops
	assign busoffOut = fc_r[2];
	assign haltOut = fc_r[3];
endmodule // csef_top

// [verilog/csef_regs.svh]
`ifndef CSEF_REGS_SVH
`define CSEF_REGS_SVH
`define CSEF_OFF_CTRL 12'h000
`define CSEF_OFF_STATE 12'h004
`define CSEF_OFF_SMODE 12'h008
`define CSEF_OFF_SRES 12'h00C
`define CSEF_OFF_CHTAB 12'h010
`define CSEF_OFF_IEN 12'h014
`define CSEF_OFF_ISRC 12'h018
`define CSEF_OFF_LOST 12'h01C
`define CSEF_OFF_RXC 12'h020
`define CSEF_OFF_TXC 12'h024
`define CSEF_OFF_FIFO 12'h028
`define CSEF_OFF_MINV 12'h02C
`define CSEF_OFF_ERRCNT 12'h030
`define CSEF_OFF_MBID 12'h034
`define CSEF_OFF_MASK 12'h038
`define CSEF_OFF_ICTL 12'h03C
`define CSEF_WARN_LIMIT 9'h060
`define CSEF_PASSIVE_LIMIT 9'h080
`define CSEF_BUSOFF_LIMIT 9'h100
`define CSEF_RECESS_RUN 4'hB
`define CSEF_RECESS_TIMES 8'h80
`define CSEF_FIFO_MBOX 5'h1C
`define CSEF_MODE_HALT 2'h2
`define CSEF_IDFM_MIXED 2'h2
`define CSEF_CTRL_RECSEL 1
`define CSEF_CTRL_FRCREC 3
`define CSEF_CTRL_OPMODE 4
`define CSEF_CTRL_IDFM 6
`define CSEF_CTRL_FIFO 8
`define CSEF_ISRC_BUSERR 0
`define CSEF_ISRC_WARN 1
`define CSEF_ISRC_PASSIVE 2
`define CSEF_ISRC_BOFF 3
`define CSEF_ISRC_BREC 4
`endif

// [verilog/csef_pkg.sv]
package csef_pkg;
	typedef enum logic [1:0] {
		SM_RX = 2'h0,
		SM_TX = 2'h1,
		SM_LOST = 2'h2,
		SM_CHAN = 2'h3
	} csef_smode_e;
	typedef enum logic [3:0] {
		FC_ACTIVE = 4'h1,
		FC_PASSIVE = 4'h2,
		FC_BUSOFF = 4'h4,
		FC_HALT = 4'h8
	} csef_fc_e;
endpackage

// [tb/csef_top_props.sv]
`timescale 1ns/10ps
module csef_top_props (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic clkEn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic frameErr,
	input wire logic errWhileTx,
	input wire logic recessRun,
	input wire logic busoffOut,
	input wire logic haltOut
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);
	logic [8:0] tecCnt;
	logic [7:0] runCnt;
	logic boPrev;
	sequence setupS;
		psel && !penable && clkEn;
	endsequence
	sequence answerS;
		pready ##1 !pready;
	endsequence
	// tx errors seen since the last bus-off exit
	always_ff @(posedge clock) begin
		boPrev <= busoffOut;
		if (sys_rst || (boPrev && !busoffOut))
			tecCnt <= '0;
		else if (frameErr && errWhileTx && clkEn && !busoffOut)
			tecCnt <= tecCnt + 9'h001;
	end
	// recessive runs seen during bus-off
	always_ff @(posedge clock) begin
		if (sys_rst || !busoffOut)
			runCnt <= '0;
		else if (recessRun && clkEn)
			runCnt <= runCnt + 8'h01;
	end
	ready_after_setup_a: assert property (setupS |=> answerS)
		else $error("pready not a single pulse after setup");
	ready_in_access_a: assert property (pready |-> psel && penable)
		else $error("pready outside access phase");
	unmapped_error_a: assert property (setupS and paddr > 12'h03C |=> pslverr)
		else $error("no error on unmapped address");
	mapped_ok_a: assert property (setupS and paddr <= 12'h03C |=> !pslverr)
		else $error("error on mapped address");
	busoff_entry_a: assert property (
		tecCnt == 9'h0FF && frameErr && errWhileTx && clkEn && !busoffOut
		&& !haltOut |-> ##[1:2] (busoffOut || haltOut))
		else $error("bus-off not entered at 256 tx errors");
	busoff_stays_a: assert property (
		busoffOut && runCnt < 8'h7F && !(psel && pwrite) |=> busoffOut)
		else $error("bus-off left early");
	busoff_exit_a: assert property (
		busoffOut && runCnt == 8'h7F && recessRun && clkEn
		|-> ##[1:2] !busoffOut)
		else $error("bus-off not left after 128 runs");
	freeze_hold_a: assert property (!clkEn |=> $stable(busoffOut) && $stable(haltOut))
		else $error("state moved while frozen");
endmodule // csef_top_props

// [tb/csef_can_node.sv]
`timescale 1ns/10ps
module csef_can_node (
	input wire logic clock,
	output logic frameErr,
	output logic errWhileTx,
	output logic recessRun,
	output logic rxArrive,
	output logic rxDone,
	output logic [4:0] rxMbox,
	output logic txDone,
	output logic [4:0] txMbox
);
	initial begin
		{frameErr, errWhileTx, recessRun, rxArrive, rxDone, rxMbox} = '0;
		{txDone, txMbox} = '0;
	end
	task automatic errs(input int n, input logic tx);
		repeat (n) begin
			@(posedge clock);
			{frameErr, errWhileTx} <= {1'b1, tx};
			@(posedge clock);
			{frameErr, errWhileTx} <= {1'b0, ~tx};
		end
	endtask
	task automatic runs(input int n);
		repeat (n) begin
			@(posedge clock);
			recessRun <= 1'b1;
			@(posedge clock);
			recessRun <= 1'b0;
		end
	endtask
	// t=1 transmit complete, t=0 message stored
	task automatic msg(input logic t, input logic [4:0] mb);
		@(posedge clock);
		{rxArrive, rxDone, txDone, rxMbox, txMbox} <= {!t, !t, t, mb, mb};
		@(posedge clock);
		{rxArrive, rxDone, txDone, rxMbox, txMbox} <= {3'b000, ~mb, ~mb};
	endtask
endmodule // csef_can_node

// [tb/tb_csef_top.sv]
`timescale 1ns/10ps
`include "csef_regs.svh"
module tb_csef_top;
	logic clock, sys_rst, clkEn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic frameErr, errWhileTx, recessRun, rxArrive, rxDone, txDone;
	logic rxIde, rxRtr, acceptOut, busoffOut, haltOut;
	logic [4:0] rxMbox, txMbox, filtMbox;
	logic [28:0] rxId;
	logic [32:0] expQ[$], mskQ[$];
	int n_fail, total_checks;
	csef_top u_csef_top (.clock(clock), .sys_rst(sys_rst), .clkEn(clkEn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.frameErr(frameErr), .errWhileTx(errWhileTx), .recessRun(recessRun),
		.rxArrive(rxArrive), .rxMbox(rxMbox), .rxDone(rxDone),
		.txMbox(txMbox), .txDone(txDone), .fifoLevelPush(1'b0),
		.fifoLevelPop(1'b0), .rxId(rxId), .rxIde(rxIde), .rxRtr(rxRtr),
		.filtMbox(filtMbox), .acceptOut(acceptOut), .busoffOut(busoffOut),
		.haltOut(haltOut));
	csef_can_node u_csef_can_node (.clock(clock), .frameErr(frameErr),
		.errWhileTx(errWhileTx), .recessRun(recessRun), .rxArrive(rxArrive),
		.rxDone(rxDone), .rxMbox(rxMbox), .txDone(txDone), .txMbox(txMbox));
	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end
	task automatic test_done();
		if (n_fail == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string s, input logic [32:0] e, g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [32:0] e, m);
		@(posedge clock);
		{psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
		expQ.push_back(e);
		mskQ.push_back(m);
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		{psel, penable} <= 2'b00;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, '0, 33'h100000000);
	endtask
	task automatic rd(input logic [11:0] a, input logic [32:0] e, m);
		apb(1'b0, a, '0, e, m);
	endtask
	task automatic rst();
		sys_rst <= 1'b1;
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
	endtask
	always @(posedge clock) begin : mon
		logic [32:0] e, m;
		if (psel && penable && pready === 1'b1) begin
			e = expQ.pop_front();
			m = mskQ.pop_front();
			chk("apb", e & m, {pslverr, prdata} & m);
		end
	end
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		test_done();
	end
	initial begin
		static logic [32:0] srch[4] = '{33'h0, 33'h3, 33'h5, 33'h80};
		logic [28:0] mbid, msk;
		logic [31:0] minv;
		logic ok;
		{sys_rst, psel, penable, pwrite, paddr, pwdata, rxIde, rxRtr} = '0;
		{filtMbox, rxId} = '0;
		clkEn = 1'b1;
		void'($urandom(67));
		rst();
		clkEn <= 1'b0;
		repeat (3) @(posedge clock);
		clkEn <= 1'b1;
		rd(`CSEF_OFF_CTRL, 33'h10, '1);
		rd(12'h040, 33'h100000000, '1);
		wr(`CSEF_OFF_IEN, 32'h1F);
		rd(`CSEF_OFF_IEN, 33'h1F, 33'h1F);
		wr(`CSEF_OFF_CTRL, 32'h0);
		wr(`CSEF_OFF_SMODE, 32'h3);
		wr(`CSEF_OFF_CHTAB, 32'h29);
		foreach (srch[i]) rd(`CSEF_OFF_SRES, srch[i], 33'h9F);
		u_csef_can_node.msg(1'b0, 5'h07);
		u_csef_can_node.msg(1'b0, 5'h03);
		u_csef_can_node.msg(1'b1, 5'h0C);
		u_csef_can_node.msg(1'b1, 5'h04);
		u_csef_can_node.msg(1'b0, 5'h03);
		u_csef_can_node.msg(1'b0, 5'h09);
		u_csef_can_node.msg(1'b0, 5'h09);
		wr(`CSEF_OFF_SMODE, 32'h0);
		rd(`CSEF_OFF_SRES, 33'h3, 33'h9F);
		wr(`CSEF_OFF_SMODE, 32'h1);
		rd(`CSEF_OFF_SRES, 33'h4, 33'h9F);
		wr(`CSEF_OFF_SMODE, 32'h2);
		rd(`CSEF_OFF_SRES, 33'h3, 33'h9F);
		wr(`CSEF_OFF_LOST, 32'h8);
		rd(`CSEF_OFF_SRES, 33'h9, 33'h9F);
		wr(`CSEF_OFF_LOST, 32'h200);
		rd(`CSEF_OFF_SRES, 33'h80, 33'h80);
		wr(`CSEF_OFF_CTRL, 32'h100);
		repeat (5) u_csef_can_node.msg(1'b0, 5'h1C);
		rd(`CSEF_OFF_SRES, 33'h1C, 33'h9F);
		rd(`CSEF_OFF_FIFO, 33'h11, '1);
		mbid = 29'($urandom);
		minv = $urandom;
		wr(`CSEF_OFF_MBID, {3'b000, mbid});
		wr(`CSEF_OFF_MINV, minv);
		for (int k = 0; k < 24; k++) begin
			if (k == 12) begin
				wr(`CSEF_OFF_CTRL, 32'h80);
			end
			msk = 29'($urandom);
			wr(`CSEF_OFF_MASK, {3'b001, msk});
			@(posedge clock);
			{filtMbox, rxIde, rxRtr} <= 7'($urandom);
			rxId <= mbid ^ (29'h1 << ($urandom % 32));
			repeat (2) @(posedge clock);
			ok = ((rxId ^ mbid) & (minv[filtMbox] ? '1 : msk)
				& (rxIde ? '1 : 29'h1FFC0000)) == 0 && !rxRtr
				&& !(k >= 12 && rxIde && minv[filtMbox]);
			chk("acceptOut", 33'(ok), 33'(acceptOut));
		end
		u_csef_can_node.errs(5, 1'b0);
		u_csef_can_node.errs(95, 1'b1);
		rd(`CSEF_OFF_ERRCNT, 33'h005F0005, '1);
		rd(`CSEF_OFF_ISRC, 33'h0, 33'h2);
		u_csef_can_node.errs(1, 1'b1);
		rd(`CSEF_OFF_ISRC, 33'h2, 33'h2);
		u_csef_can_node.errs(32, 1'b1);
		rd(`CSEF_OFF_STATE, 33'h2, 33'h6);
		rd(`CSEF_OFF_ISRC, 33'h4, 33'h4);
		u_csef_can_node.errs(128, 1'b1);
		rd(`CSEF_OFF_STATE, 33'h4, 33'h4);
		rd(`CSEF_OFF_ISRC, 33'h8, 33'h8);
		u_csef_can_node.runs(127);
		repeat (2) @(posedge clock);
		chk("busoffOut", 33'h1, 33'(busoffOut));
		u_csef_can_node.runs(1);
		repeat (2) @(posedge clock);
		chk("busoffOut", 33'h0, 33'(busoffOut));
		rd(`CSEF_OFF_ISRC, 33'h10, 33'h10);
		rd(`CSEF_OFF_ERRCNT, 33'h0, '1);
		for (int m = 0; m <= 3; m++) begin
			rst();
			wr(`CSEF_OFF_CTRL, 32'h10 | 32'(m << 1));
			wr(`CSEF_OFF_IEN, 32'h1F);
			wr(`CSEF_OFF_CTRL, 32'(m << 1));
			u_csef_can_node.errs(256, 1'b1);
			repeat (2) @(posedge clock);
			chk("haltOut", 33'(m == 1), 33'(haltOut));
			chk("busoffOut", 33'(m != 1), 33'(busoffOut));
			if (m == 0) begin
				wr(`CSEF_OFF_CTRL, 32'h8);
				rd(`CSEF_OFF_CTRL, 33'h0, '1);
			end
			if (m == 2) begin
				u_csef_can_node.runs(128);
				repeat (2) @(posedge clock);
				chk("haltOut", 33'h1, 33'(haltOut));
			end
			if (m == 3) begin
				wr(`CSEF_OFF_CTRL, 32'h26);
			end
			repeat (2) @(posedge clock);
			chk("haltOut", 33'(m != 0), 33'(haltOut));
			chk("busoffOut", 33'h0, 33'(busoffOut));
			rd(`CSEF_OFF_ISRC, 33'(m == 2) << 4, 33'h10);
		end
		test_done();
	end
endmodule // tb_csef_top
bind csef_top csef_top_props u_csef_top_props (.clock(clock),
	.sys_rst(sys_rst), .clkEn(clkEn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
	.frameErr(frameErr), .errWhileTx(errWhileTx), .recessRun(recessRun),
	.busoffOut(busoffOut), .haltOut(haltOut));
